// ---- srs_regs.svh ----
// Offsets, field positions, reset values and counts of the standby and
// reset sequencer. Assumes a 100 MHz clk_sys and byte addresses on the bus.
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH

`define SRS_ADDR_W 4
`define SRS_OFF_CTRL 4'h0
`define SRS_OFF_STANDBY 4'h4
`define SRS_OFF_STATUS 4'h8

`define SRS_CTRL_PCE 0
`define SRS_CTRL_SEL_LO 1
`define SRS_CTRL_SEL_HI 3
`define SRS_CTRL_TAP10 4
`define SRS_STANDBY_SLEEP 0

`define SRS_RST_PCE 1'h1
`define SRS_RST_SEL 3'h7
`define SRS_RST_TAP10 1'h1

`define SRS_STAT_STATE_LO 0
`define SRS_STAT_STATE_HI 3
`define SRS_STAT_LVD 4
`define SRS_STAT_RESET 5
`define SRS_STAT_STAB_OK 6

`define SRS_EXT_RST_MIN_CYC 2
`define SRS_STAB_TAP_BASE 3
`define SRS_PRESC_W 11
`define SRS_BIT_W 8

`endif

// ---- srs_pkg.sv ----
// Types shared by the standby and reset sequencer.
// Assumes srs_regs.svh supplies the numeric constants.
package srs_pkg;

    typedef enum logic [3:0] {
        S_OSCWAIT,
        S_PORCNT,
        S_XRST,
        S_RUN,
        S_SLEEP,
        S_STOP,
        S_STAB,
        S_LVD
    } srs_state_t;

    typedef struct packed {
        logic osc;
        logic cpu;
        logic periph;
        logic wdt;
        logic timer;
        logic bit_timer;
    } srs_clk_gate_t;

    typedef struct packed {
        logic irq_block;
        logic port_input;
        logic remote_out_low;
    } srs_lvd_force_t;

endpackage : srs_pkg

// ---- srs_sequencer.sv ----
// Standby, reset and low-voltage sequencer with an Avalon-MM register slave.
// Assumes pins arrive asynchronously, CPU strobes share clk_sys.
// Function
// - Global enable on: wake vectors to service
// - Pending enabled interrupt refuses standby entry
// - Gate oscillator and counters per standby mode
// - Power-on reset lasts two-to-nineteen cycles
// - Power-on pulse clears prescaler, timer, detector
// - Interval timer on tap ten; overflow ends reset
// - Stabilization count starts after oscillator start
// - Low supply enters low-voltage mode
// - Low-voltage mode blocks, stops, forces ports
// - Low-voltage pull-ups follow factory option
// - Only reset leaves low-voltage mode
// - Global enable off: resume after standby
// - STOP release waits selected stabilization time
`include "srs_regs.svh"

module srs_sequencer #(
    parameter int NIRQ = 8,
    parameter int NPORT = 21,
    parameter logic [20:0] PULLUP_OPT = 21'h1fffff,
    parameter int PRESC_W = `SRS_PRESC_W,
    parameter int BIT_W = `SRS_BIT_W
) (
    input wire logic clk_sys, // Oscillator clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [`SRS_ADDR_W-1:0] address, // Byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    input wire logic reset_pin_n, // External reset pin
    input wire logic por_pulse, // Power-on detection pulse
    input wire logic osc_started, // Oscillator running
    input wire logic supply_low, // Supply comparator output
    input wire logic [NIRQ-1:0] irq_flag, // Interrupt request flags
    input wire logic [NIRQ-1:0] irq_enable, // Interrupt enable flags
    input wire logic global_ie, // processor_status_word I bit
    input wire logic stop_req, // STOP instruction strobe
    output logic sys_reset, // Internal reset
    output srs_pkg::srs_clk_gate_t clk_gate, // Clock enables
    output srs_pkg::srs_lvd_force_t lvd_force, // Low-voltage forcing
    output logic [20:0] port_pullup, // Port pull-up enables
    output logic standby_refused, // Entry refused pulse
    output logic wake_vector, // Wake to service routine
    output logic wake_resume, // Wake to next instruction
    output logic [7:0] wake_index, // Waking interrupt
    output logic bit_overflow // Interval timer overflow
);

    srs_pkg::srs_state_t state;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic pin_n_s;
    logic por_s;
    logic osc_s;
    logic low_s;
    logic [1:0] xrst_cnt;
    logic xrst_go;
    logic [PRESC_W-1:0] presc;
    logic [PRESC_W-1:0] presc_prev;
    logic [BIT_W-1:0] bit_cnt;
    logic bit_tick;
    logic bit_ovf;
    logic ovf;
    logic pce;
    logic [2:0] clk_sel;
    logic tap10_src;
    logic sleep_req;
    logic stab_from_rst;
    logic stab_ie;
    logic stab_wake;
    logic [NIRQ-1:0] pend;
    logic any_pend;
    logic stab_ok;
    logic go_standby;
    logic acc;

    function automatic logic tap_rise(input logic [PRESC_W-1:0] prev,
                                      input logic [PRESC_W-1:0] cur,
                                      input int idx);
        int i;
        i = (idx > PRESC_W - 1) ? PRESC_W - 1 : idx;
        return cur[i] & ~prev[i];
    endfunction : tap_rise

    function automatic logic [7:0] first_set(input logic [NIRQ-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = NIRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 8'(i);
            end
        end
        return r;
    endfunction : first_set

    // Only the second stage is read; the first stage may be metastable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1 <= 4'h1;
            sync2 <= 4'h1;
        end else begin
            sync1 <= {supply_low, osc_started, por_pulse, reset_pin_n};
            sync2 <= sync1;
        end
    end
    assign pin_n_s = sync2[0];
    assign por_s = sync2[1];
    assign osc_s = sync2[2];
    assign low_s = sync2[3];

    // Short glitches on the pin are ignored
    always_ff @(posedge clk_sys) begin
        if (rst || pin_n_s) begin
            xrst_cnt <= 2'h0;
        end else if (xrst_cnt != 2'(`SRS_EXT_RST_MIN_CYC)) begin
            xrst_cnt <= xrst_cnt + 2'h1;
        end
    end
    assign xrst_go = !pin_n_s && (xrst_cnt == 2'(`SRS_EXT_RST_MIN_CYC - 1) ||
                     xrst_cnt == 2'(`SRS_EXT_RST_MIN_CYC));

    assign pend = irq_flag & irq_enable;
    assign any_pend = |pend;
    assign stab_ok = tap10_src | pce;
    assign go_standby = sleep_req | stop_req;

    // Prescaler holds in STOP and low-voltage mode, cleared by any reset
    always_ff @(posedge clk_sys) begin
        if (rst || state == srs_pkg::S_OSCWAIT ||
            state == srs_pkg::S_XRST) begin
            presc <= '0;
            presc_prev <= '0;
        end else begin
            presc_prev <= presc;
            if (state != srs_pkg::S_STOP && state != srs_pkg::S_LVD) begin
                presc <= presc + 1'b1;
            end
        end
    end

    always_comb begin
        bit_tick = 1'b0;
        case (state)
            srs_pkg::S_PORCNT: begin
                bit_tick = tap_rise(presc_prev, presc, PRESC_W - 1);
            end
            srs_pkg::S_STAB: begin
                bit_tick = tap_rise(presc_prev, presc,
                    `SRS_STAB_TAP_BASE + int'(clk_sel));
            end
            srs_pkg::S_RUN: begin
                bit_tick = tap10_src ? tap_rise(presc_prev, presc, PRESC_W - 1)
                    : (pce & tap_rise(presc_prev, presc,
                    `SRS_STAB_TAP_BASE + int'(clk_sel)));
            end
            srs_pkg::S_SLEEP: begin
                bit_tick = tap10_src &
                    tap_rise(presc_prev, presc, PRESC_W - 1);
            end
            default: begin
                bit_tick = 1'b0;
            end
        endcase
    end
    assign bit_ovf = bit_tick && (&bit_cnt);

    // Counter and overflow detector restart so each stabilization is full
    always_ff @(posedge clk_sys) begin
        if (rst || state == srs_pkg::S_OSCWAIT ||
            state == srs_pkg::S_XRST || state == srs_pkg::S_STOP) begin
            bit_cnt <= '0;
            ovf <= 1'b0;
        end else begin
            if (bit_tick) begin
                bit_cnt <= bit_cnt + 1'b1;
            end
            if (bit_ovf) begin
                ovf <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= srs_pkg::S_OSCWAIT;
            stab_from_rst <= 1'b0;
            stab_ie <= 1'b0;
            stab_wake <= 1'b0;
        end else if (por_s) begin
            state <= srs_pkg::S_OSCWAIT;
        end else if (xrst_go) begin
            state <= srs_pkg::S_XRST;
        end else if (low_s && state != srs_pkg::S_OSCWAIT &&
                     state != srs_pkg::S_PORCNT &&
                     state != srs_pkg::S_XRST) begin
            state <= srs_pkg::S_LVD;
        end else begin
            case (state)
                srs_pkg::S_OSCWAIT: begin
                    if (osc_s) begin
                        state <= srs_pkg::S_PORCNT;
                    end
                end
                srs_pkg::S_PORCNT: begin
                    if (ovf) begin
                        state <= srs_pkg::S_RUN;
                    end
                end
                srs_pkg::S_XRST: begin
                    stab_from_rst <= 1'b1;
                    stab_wake <= 1'b0;
                    state <= srs_pkg::S_STAB;
                end
                srs_pkg::S_RUN: begin
                    if (go_standby && !any_pend) begin
                        state <= stop_req ? srs_pkg::S_STOP
                            : srs_pkg::S_SLEEP;
                    end
                end
                srs_pkg::S_SLEEP: begin
                    if (any_pend) begin
                        state <= srs_pkg::S_RUN;
                    end
                end
                srs_pkg::S_STOP: begin
                    if (any_pend && stab_ok) begin
                        stab_from_rst <= 1'b0;
                        stab_wake <= 1'b1;
                        stab_ie <= global_ie;
                        state <= srs_pkg::S_STAB;
                    end
                end
                srs_pkg::S_STAB: begin
                    if (ovf) begin
                        state <= srs_pkg::S_RUN;
                    end
                end
                srs_pkg::S_LVD: begin
                    state <= srs_pkg::S_LVD;
                end
                default: begin
                    state <= srs_pkg::S_OSCWAIT;
                end
            endcase
        end
    end

    // Wake and refusal pulses for the processor core
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake_vector <= 1'b0;
            wake_resume <= 1'b0;
            wake_index <= 8'h00;
            standby_refused <= 1'b0;
        end else begin
            wake_vector <= 1'b0;
            wake_resume <= 1'b0;
            standby_refused <= 1'b0;
            if (!por_s && !xrst_go && !low_s) begin
                if (state == srs_pkg::S_SLEEP && any_pend) begin
                    wake_vector <= global_ie;
                    wake_resume <= !global_ie;
                    wake_index <= first_set(pend);
                end else if (state == srs_pkg::S_STOP && any_pend &&
                             stab_ok) begin
                    wake_index <= first_set(pend);
                end else if (state == srs_pkg::S_STAB && ovf &&
                             stab_wake) begin
                    wake_vector <= stab_ie;
                    wake_resume <= !stab_ie;
                end else if (state == srs_pkg::S_RUN && go_standby &&
                             any_pend) begin
                    standby_refused <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sys_reset <= 1'b1;
            clk_gate <= '0;
            lvd_force <= '0;
            port_pullup <= '0;
            bit_overflow <= 1'b0;
        end else begin
            sys_reset <= state == srs_pkg::S_OSCWAIT ||
                state == srs_pkg::S_PORCNT || state == srs_pkg::S_XRST ||
                (state == srs_pkg::S_STAB && stab_from_rst);
            bit_overflow <= bit_ovf && state == srs_pkg::S_RUN ||
                bit_ovf && state == srs_pkg::S_SLEEP;
            clk_gate.osc <= state != srs_pkg::S_STOP &&
                state != srs_pkg::S_LVD;
            clk_gate.cpu <= state == srs_pkg::S_RUN;
            clk_gate.wdt <= state == srs_pkg::S_RUN;
            clk_gate.timer <= state == srs_pkg::S_RUN && pce;
            clk_gate.periph <= state == srs_pkg::S_RUN && pce;
            clk_gate.bit_timer <= state == srs_pkg::S_RUN ||
                state == srs_pkg::S_STAB || state == srs_pkg::S_PORCNT ||
                (state == srs_pkg::S_SLEEP && tap10_src);
            lvd_force.irq_block <= state == srs_pkg::S_LVD;
            lvd_force.port_input <= state == srs_pkg::S_LVD;
            lvd_force.remote_out_low <= state == srs_pkg::S_LVD;
            port_pullup <= (state == srs_pkg::S_LVD) ? PULLUP_OPT
                : 21'h000000;
        end
    end

    // One wait cycle per access; the transfer completes when waitrequest low
    assign acc = (read || write) && !waitrequest;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                readdata <= 32'h00000000;
                case (address)
                    `SRS_OFF_CTRL: begin
                        readdata[`SRS_CTRL_PCE] <= pce;
                        readdata[`SRS_CTRL_SEL_HI:`SRS_CTRL_SEL_LO] <= clk_sel;
                        readdata[`SRS_CTRL_TAP10] <= tap10_src;
                    end
                    `SRS_OFF_STATUS: begin
                        readdata[`SRS_STAT_STATE_HI:`SRS_STAT_STATE_LO] <=
                            state;
                        readdata[`SRS_STAT_LVD] <= state == srs_pkg::S_LVD;
                        readdata[`SRS_STAT_RESET] <= sys_reset;
                        readdata[`SRS_STAT_STAB_OK] <= stab_ok;
                    end
                    default: begin
                        readdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Hardware setting the peripheral clock on STOP release wins over a write
    always_ff @(posedge clk_sys) begin
        if (rst || sys_reset) begin
            pce <= `SRS_RST_PCE;
            clk_sel <= `SRS_RST_SEL;
            tap10_src <= `SRS_RST_TAP10;
            sleep_req <= 1'b0;
        end else begin
            sleep_req <= 1'b0;
            if (acc && write && address == `SRS_OFF_CTRL) begin
                pce <= writedata[`SRS_CTRL_PCE];
                clk_sel <= writedata[`SRS_CTRL_SEL_HI:`SRS_CTRL_SEL_LO];
                tap10_src <= writedata[`SRS_CTRL_TAP10];
            end
            if (acc && write && address == `SRS_OFF_STANDBY) begin
                sleep_req <= writedata[`SRS_STANDBY_SLEEP];
            end
            if (state == srs_pkg::S_STAB && ovf) begin
                pce <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_vector_wake;
        state == srs_pkg::S_SLEEP && any_pend && global_ie && !por_s &&
        !xrst_go && !low_s |=> wake_vector && !wake_resume &&
        state == srs_pkg::S_RUN;
    endproperty
    a_vector_wake: assert property (p_vector_wake)
        else $error("sleep wake with enable set did not vector");

    property p_refuse;
        state == srs_pkg::S_RUN && go_standby && any_pend && !por_s &&
        !xrst_go && !low_s |=> state == srs_pkg::S_RUN && standby_refused;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("standby entered with interrupt pending");

    property p_stop_gates;
        state == srs_pkg::S_STOP |=> !clk_gate.osc && !clk_gate.cpu &&
        !clk_gate.bit_timer && $stable(presc);
    endproperty
    a_stop_gates: assert property (p_stop_gates)
        else $error("clock or counter running in stop");

    property p_ext_reset;
        !pin_n_s ##1 !pin_n_s && !por_s |=> state == srs_pkg::S_XRST ##1
        sys_reset;
    endproperty
    a_ext_reset: assert property (p_ext_reset)
        else $error("held reset pin not recognised");

    property p_por_clear;
        por_s |=> state == srs_pkg::S_OSCWAIT ##1 presc == '0 && !ovf;
    endproperty
    a_por_clear: assert property (p_por_clear)
        else $error("power-on pulse did not clear the chain");

    property p_por_end;
        state == srs_pkg::S_PORCNT ##1 state == srs_pkg::S_PORCNT && ovf &&
        !por_s && !xrst_go |=> state == srs_pkg::S_RUN ##1 !sys_reset;
    endproperty
    a_por_end: assert property (p_por_end)
        else $error("overflow did not end power-on reset");

    property p_osc_wait;
        state == srs_pkg::S_OSCWAIT && !osc_s && !por_s && !xrst_go
        |=> state == srs_pkg::S_OSCWAIT && presc == '0;
    endproperty
    a_osc_wait: assert property (p_osc_wait)
        else $error("stabilization count began before oscillator");

    property p_lvd_enter;
        state == srs_pkg::S_RUN && low_s && !por_s && !xrst_go
        |=> state == srs_pkg::S_LVD ##1 lvd_force.port_input &&
        lvd_force.remote_out_low && !clk_gate.osc &&
        port_pullup == PULLUP_OPT;
    endproperty
    a_lvd_enter: assert property (p_lvd_enter)
        else $error("low supply did not force low-voltage state");

    property p_lvd_hold;
        state == srs_pkg::S_LVD && !por_s && !xrst_go
        |=> state == srs_pkg::S_LVD;
    endproperty
    a_lvd_hold: assert property (p_lvd_hold)
        else $error("low-voltage mode left without reset");

    property p_stab_done;
        state == srs_pkg::S_STAB && ovf && stab_wake && !por_s && !xrst_go &&
        !low_s |=> state == srs_pkg::S_RUN && (wake_vector ^ wake_resume)
        ##1 pce;
    endproperty
    a_stab_done: assert property (p_stab_done)
        else $error("stop release did not finish stabilization");

endmodule : srs_sequencer

// ---- srs_core_model.sv ----
// Behavioural model of the processor core, interrupt sources and reset pin.
// Assumes the bench commands it by non-blocking writes after clk_sys edges.
module srs_core_model (
    input wire logic clk_sys, // Oscillator clock
    input wire logic set_irq, // Raise one request flag
    input wire logic [2:0] irq_sel, // Which flag to raise
    input wire logic [7:0] en_mask, // Enable flags presented
    input wire logic gie, // Global interrupt enable
    input wire logic do_stop, // Execute one STOP
    input wire logic pin_rst, // Pull the reset pin low
    input wire logic wake_vector, // Wake to service routine
    input wire logic wake_resume, // Wake to next instruction
    input wire logic [7:0] wake_index, // Waking interrupt
    output logic [7:0] irq_flag = 8'h00, // Request flags
    output logic [7:0] irq_enable, // Enable flags
    output logic global_ie, // Status word interrupt bit
    output logic stop_req = 1'b0, // STOP strobe
    output logic reset_pin_n // Reset pin with pull-up
);
    logic [1:0] low_cnt = 2'h0;
    assign irq_enable = en_mask;
    assign global_ie = gie;
    // A wake acknowledges its request; a raise in the same cycle still wins
    always @(posedge clk_sys) begin
        if (wake_vector === 1'b1 || wake_resume === 1'b1) begin
            irq_flag[wake_index[2:0]] <= 1'b0;
        end
        if (set_irq) begin
            irq_flag[irq_sel] <= 1'b1;
        end
        stop_req <= do_stop;
    end
    // Three low cycles: one spare over the two-cycle minimum of the pin glitch filter
    always @(posedge clk_sys) begin
        if (pin_rst) begin
            low_cnt <= 2'h3;
        end else if (low_cnt != 2'h0) begin
            low_cnt <= low_cnt - 2'h1;
        end
    end
    assign reset_pin_n = (low_cnt == 2'h0);
endmodule : srs_core_model

// ---- tb.sv ----
// Self-checking bench of the standby and reset sequencer.
// Assumes srs_regs.svh offsets and short counts PRESC_W 4, BIT_W 3.
`include "srs_regs.svh"
`define CHK(a, b, m) compares++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t %s", $time, m); end
`define WAITC(c) n = 0; while (!(c) && n < 3000) begin \
    @(posedge clk_sys); n++; end if (n >= 3000) begin fails++; \
    print_verdict(); end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // First tap rise lands half a prescaler period in, hence the window
    localparam int POR_LO = 120;
    localparam int POR_HI = 136;
    localparam int STAB_MIN = 112;
    logic clk_sys = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q, s = 32'h7f94;
    logic waitrequest, por_pulse = 1'b0, osc_started = 1'b0;
    logic supply_low = 1'b0, set_irq = 1'b0, gie = 1'b0, do_stop = 1'b0;
    logic pin_rst = 1'b0, sys_reset, reset_pin_n, global_ie, stop_req;
    logic [2:0] irq_sel = 3'h0, idx;
    logic [7:0] en_mask = 8'h00, irq_flag, irq_enable, wake_index;
    logic standby_refused, wake_vector, wake_resume, bit_overflow;
    logic [20:0] port_pullup;
    srs_pkg::srs_clk_gate_t clk_gate;
    srs_pkg::srs_lvd_force_t lvd_force;
    int fails = 0, compares = 0, n, k;
    always #5 clk_sys = ~clk_sys;
    srs_sequencer #(.PRESC_W(4), .BIT_W(3)) dut (.clk_sys(clk_sys),
        .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .reset_pin_n(reset_pin_n),
        .por_pulse(por_pulse), .osc_started(osc_started),
        .supply_low(supply_low), .irq_flag(irq_flag),
        .irq_enable(irq_enable), .global_ie(global_ie),
        .stop_req(stop_req), .sys_reset(sys_reset), .clk_gate(clk_gate),
        .lvd_force(lvd_force), .port_pullup(port_pullup),
        .standby_refused(standby_refused), .wake_vector(wake_vector),
        .wake_resume(wake_resume), .wake_index(wake_index),
        .bit_overflow(bit_overflow));
    srs_core_model partner (.clk_sys(clk_sys), .set_irq(set_irq),
        .irq_sel(irq_sel), .en_mask(en_mask), .gie(gie), .do_stop(do_stop),
        .pin_rst(pin_rst), .wake_vector(wake_vector),
        .wake_resume(wake_resume), .wake_index(wake_index),
        .irq_flag(irq_flag), .irq_enable(irq_enable),
        .global_ie(global_ie), .stop_req(stop_req),
        .reset_pin_n(reset_pin_n));
    function automatic logic [31:0] rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : rnd
    function automatic logic [31:0] exp_ctrl(input logic [31:0] v);
        return v & 32'h0000001f;
    endfunction : exp_ctrl
    function automatic logic [31:0] exp_status(input logic [3:0] st,
                                               input logic ok);
        return {25'h0, ok, 2'b00, st};
    endfunction : exp_status
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // Avalon-MM transfer; the extra edge keeps back-to-back calls race-free
    task automatic bus(input logic [3:0] a, input logic wr,
                       input logic [31:0] d);
        int w;
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        w = 0;
        do begin
            @(posedge clk_sys);
            w++;
        end while (waitrequest !== 1'b0 && w < 100);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (w >= 100) begin
            fails++;
            print_verdict();
        end
        @(posedge clk_sys);
    endtask : bus
    task automatic raise(input logic [2:0] i);
        irq_sel <= i;
        set_irq <= 1'b1;
        @(posedge clk_sys);
        set_irq <= 1'b0;
        @(posedge clk_sys);
    endtask : raise
    task automatic stop_cpu();
        do_stop <= 1'b1;
        @(posedge clk_sys);
        do_stop <= 1'b0;
        `WAITC(clk_gate.osc === 1'b0)
        `CHK(clk_gate.cpu, 1'b0, "cpu clock runs in stop")
    endtask : stop_cpu
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (20) @(posedge clk_sys);
        `CHK(sys_reset, 1'b1, "reset ended before oscillator")
        osc_started <= 1'b1;
        `WAITC(sys_reset === 1'b0)
        `CHK(n >= POR_LO && n <= POR_HI, 1'b1, "power-on length")
        bus(`SRS_OFF_CTRL, 1'b0, 32'h0);
        `CHK(q, 32'h1f, "control reset value")
        bus(`SRS_OFF_STATUS, 1'b0, 32'h0);
        `CHK(q, exp_status(srs_pkg::S_RUN, 1'b1), "status after reset")
        `CHK(clk_gate, 6'h3f, "run clock gates")
        bus(4'hc, 1'b0, 32'h0);
        `CHK(q, 32'h0, "unmapped read")
        for (int i = 0; i < 4; i++) begin
            k = rnd();
            bus(`SRS_OFF_CTRL, 1'b1, k);
            bus(`SRS_OFF_CTRL, 1'b0, 32'h0);
            `CHK(q, exp_ctrl(k), "control readback")
        end
        bus(`SRS_OFF_CTRL, 1'b1, 32'h1f);
        `WAITC(bit_overflow === 1'b1)
        `CHK(n <= POR_HI, 1'b1, "interval timer stalled in run")
        idx = 3'(rnd());
        en_mask <= 8'hff;
        raise(idx);
        bus(`SRS_OFF_STANDBY, 1'b1, 32'h1);
        `WAITC(standby_refused === 1'b1)
        bus(`SRS_OFF_STATUS, 1'b0, 32'h0);
        `CHK(q[3:0], srs_pkg::S_RUN, "standby entered while pending")
        for (int g = 0; g < 2; g++) begin
            gie <= g[0];
            en_mask <= 8'h00;
            bus(`SRS_OFF_STANDBY, 1'b1, 32'h1);
            `WAITC(clk_gate.cpu === 1'b0)
            `CHK({clk_gate.osc, clk_gate.bit_timer}, 2'b11, "sleep gates")
            `CHK({clk_gate.wdt, clk_gate.timer}, 2'b00, "sleep timers")
            `CHK(clk_gate.periph, 1'b0, "sleep peripherals")
            if (g == 1) begin
                idx = 3'(rnd());
                raise(idx);
            end
            en_mask <= 8'hff;
            `WAITC(wake_vector === 1'b1 || wake_resume === 1'b1)
            `CHK(wake_vector, g[0], "vector choice")
            `CHK(wake_resume, !g[0], "resume choice")
            `CHK(wake_index, {5'h0, idx}, "wake index")
        end
        en_mask <= 8'h00;
        bus(`SRS_OFF_CTRL, 1'b1, 32'h10);
        idx = 3'(rnd());
        raise(idx);
        stop_cpu();
        en_mask <= 8'hff;
        `WAITC(wake_vector === 1'b1 || wake_resume === 1'b1)
        `CHK(n >= STAB_MIN, 1'b1, "stop wake before stabilization")
        bus(`SRS_OFF_CTRL, 1'b0, 32'h0);
        `CHK(q[0], 1'b1, "peripheral clock not forced")
        en_mask <= 8'h00;
        bus(`SRS_OFF_CTRL, 1'b1, 32'h0);
        raise(idx);
        stop_cpu();
        en_mask <= 8'hff;
        k = 0;
        repeat (300) begin
            @(posedge clk_sys);
            if (wake_vector === 1'b1 || wake_resume === 1'b1) k++;
        end
        `CHK(k, 0, "stop left without timer clock")
        pin_rst <= 1'b1;
        @(posedge clk_sys);
        pin_rst <= 1'b0;
        en_mask <= 8'h00;
        `WAITC(sys_reset === 1'b1)
        `WAITC(sys_reset === 1'b0)
        bus(`SRS_OFF_CTRL, 1'b0, 32'h0);
        `CHK(q, 32'h1f, "pin reset did not restore control")
        supply_low <= 1'b1;
        `WAITC(lvd_force === 3'b111)
        `CHK(port_pullup, 21'h1fffff, "low-voltage pull-ups")
        `CHK(clk_gate.osc, 1'b0, "oscillator runs in low voltage")
        en_mask <= 8'hff;
        raise(idx);
        supply_low <= 1'b0;
        k = 0;
        repeat (50) begin
            @(posedge clk_sys);
            if (wake_vector === 1'b1 || lvd_force !== 3'b111) k++;
        end
        `CHK(k, 0, "low-voltage mode left without reset")
        en_mask <= 8'h00;
        por_pulse <= 1'b1;
        repeat (3) @(posedge clk_sys);
        por_pulse <= 1'b0;
        `WAITC(lvd_force === 3'b000)
        `WAITC(sys_reset === 1'b0)
        `CHK(n >= POR_LO && n <= POR_HI, 1'b1, "por not restarted")
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        print_verdict();
    end
endmodule : tb
